// *** aqm_arbiter.v ***
// Purpose: Acquisition memory port: ADC intake, channel increment, processor arbitration.
// Assumes: ADC ports and processor strobes synchronous to CLK_I.
// Notes:   Memory address is {port, channel, word}; two ports share the 128k words.
`timescale 1ns/1ps
`default_nettype none
`include "aqm_defines.vh"
module aqm_arbiter #(
    parameter [23:0] ACT_HOLD_CYC = `AQM_ACT_HOLD_CYC,
    parameter [15:0] LT_TICK_CYC  = `AQM_LT_TICK_CYC,
    parameter        FIFO_DEPTH   = `AQM_FIFO_DEPTH,
    parameter        FIFO_AW      = 2
) (
    input  wire                     CLK_I,
    input  wire                     RST_N_I,
    input  wire [`AQM_CHAN_W-1:0]   ADC1_CHAN_I,
    input  wire                     ADC1_READY_I,
    output reg                      ADC1_ACCEPT_O,
    input  wire [`AQM_CHAN_W-1:0]   ADC2_CHAN_I,
    input  wire                     ADC2_READY_I,
    output reg                      ADC2_ACCEPT_O,
    input  wire                     LT1_GATE_I,
    input  wire                     LT2_GATE_I,
    input  wire                     LT_CLEAR_I,
    output wire [`AQM_LT_W-1:0]     LT1_COUNT_O,
    output wire [`AQM_LT_W-1:0]     LT2_COUNT_O,
    output reg                      PORT_ONE_ACTIVITY_LED_O,
    output reg                      PORT_TWO_ACTIVITY_LED_O,
    input  wire                     CPU_REQ_I,
    input  wire                     CPU_RD_N_I,
    input  wire                     CPU_WR_N_I,
    output reg                      PROCESSOR_WAIT_RELEASE_O,
    output reg                      CPU_ADDR_BUF_EN_N_O,
    output reg                      CPU_DATA_BUF_EN_N_O,
    output reg  [`AQM_ADDR_W-1:0]   MEM_AD_O,
    output reg                      MEM_AD_OE_O,
    input  wire [`AQM_DATA_W-1:0]   MEM_AD_I,
    output reg                      MEM_ALE_O,
    output reg                      MEM_CS_N_O,
    output reg                      MEM_OE_N_O,
    output reg                      MEM_WE_N_O
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_RALE = 4'h1;
    localparam [3:0] S_RD   = 4'h2;
    localparam [3:0] S_RCAP = 4'h3;
    localparam [3:0] S_INC  = 4'h4;
    localparam [3:0] S_WALE = 4'h5;
    localparam [3:0] S_WR   = 4'h6;
    localparam [3:0] S_WEND = 4'h7;
    localparam [3:0] S_GNT  = 4'h8;
    localparam       QW     = `AQM_CHAN_W + 1;

    reg  [3:0]              state_q;
    reg                     half_q;
    reg  [QW-1:0]           wadr_q;
    reg  [`AQM_CNT_W-1:0]   cnt_q;
    reg                     after_cpu_q;
    reg                     taken1_q;
    reg                     taken2_q;
    reg                     rr_q;
    reg  [23:0]             hold1_q;
    reg  [23:0]             hold2_q;

    wire                    req1;
    wire                    req2;
    wire                    sel2;
    wire                    in_valid;
    wire                    in_ready;
    wire [QW-1:0]           in_data;
    wire                    q_valid;
    wire [QW-1:0]           q_data;
    wire                    take_acq;
    wire                    q_pop;
    wire                    acc1;
    wire                    acc2;

    // A port is not taken again until it drops ready, so one conversion is one entry
    assign req1     = ADC1_READY_I & ~taken1_q & ~ADC1_ACCEPT_O;
    assign req2     = ADC2_READY_I & ~taken2_q & ~ADC2_ACCEPT_O;
    assign sel2     = req2 & (~req1 | rr_q);
    assign in_valid = req1 | req2;
    assign in_data  = sel2 ? {1'b1, ADC2_CHAN_I} : {1'b0, ADC1_CHAN_I};
    assign acc1     = in_valid & in_ready & ~sel2;
    assign acc2     = in_valid & in_ready & sel2;

    // After a grant, one queued conversion goes first so a busy processor cannot starve intake
    assign take_acq = q_valid & (~CPU_REQ_I | after_cpu_q);
    assign q_pop    = (state_q == S_IDLE) & take_acq;

    aqm_fifo #(
        .WIDTH (QW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (in_valid),
        .in_ready_o  (in_ready),
        .in_data_i   (in_data),
        .out_valid_o (q_valid),
        .out_ready_i (q_pop),
        .out_data_o  (q_data)
    );

    aqm_live_timer #(
        .CW       (`AQM_LT_W),
        .TICK_CYC (LT_TICK_CYC)
    ) u_lt1 (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .gate_i  (LT1_GATE_I),
        .clear_i (LT_CLEAR_I),
        .count_o (LT1_COUNT_O)
    );

    aqm_live_timer #(
        .CW       (`AQM_LT_W),
        .TICK_CYC (LT_TICK_CYC)
    ) u_lt2 (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .gate_i  (LT2_GATE_I),
        .clear_i (LT_CLEAR_I),
        .count_o (LT2_COUNT_O)
    );

    // Port intake and activity indicators
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ADC1_ACCEPT_O           <= 1'b0;
            ADC2_ACCEPT_O           <= 1'b0;
            taken1_q                <= 1'b0;
            taken2_q                <= 1'b0;
            rr_q                    <= 1'b0;
            hold1_q                 <= 24'h00_0000;
            hold2_q                 <= 24'h00_0000;
            PORT_ONE_ACTIVITY_LED_O <= 1'b0;
            PORT_TWO_ACTIVITY_LED_O <= 1'b0;
        end else begin
            ADC1_ACCEPT_O <= acc1;
            ADC2_ACCEPT_O <= acc2;
            taken1_q      <= (taken1_q | ADC1_ACCEPT_O) & ADC1_READY_I;
            taken2_q      <= (taken2_q | ADC2_ACCEPT_O) & ADC2_READY_I;
            if (acc1 | acc2) begin
                rr_q <= ~sel2;
            end
            if (ADC1_ACCEPT_O) begin
                hold1_q <= ACT_HOLD_CYC;
            end else if (hold1_q != 24'h00_0000) begin
                hold1_q <= hold1_q - 24'h00_0001;
            end
            if (ADC2_ACCEPT_O) begin
                hold2_q <= ACT_HOLD_CYC;
            end else if (hold2_q != 24'h00_0000) begin
                hold2_q <= hold2_q - 24'h00_0001;
            end
            PORT_ONE_ACTIVITY_LED_O <= ADC1_ACCEPT_O | (hold1_q != 24'h00_0000);
            PORT_TWO_ACTIVITY_LED_O <= ADC2_ACCEPT_O | (hold2_q != 24'h00_0000);
        end
    end

    // Memory sequencer and processor grant
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q                  <= S_IDLE;
            half_q                   <= 1'b0;
            wadr_q                   <= {QW{1'b0}};
            cnt_q                    <= 32'h0000_0000;
            after_cpu_q              <= 1'b0;
            PROCESSOR_WAIT_RELEASE_O <= 1'b0;
            CPU_ADDR_BUF_EN_N_O      <= 1'b1;
            CPU_DATA_BUF_EN_N_O      <= 1'b1;
            MEM_AD_O                 <= 17'h0_0000;
            MEM_AD_OE_O              <= 1'b0;
            MEM_ALE_O                <= 1'b0;
            MEM_CS_N_O               <= 1'b1;
            MEM_OE_N_O               <= 1'b1;
            MEM_WE_N_O               <= 1'b1;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (take_acq) begin
                        wadr_q      <= q_data;
                        half_q      <= 1'b0;
                        after_cpu_q <= 1'b0;
                        MEM_AD_O    <= {q_data, 1'b0};
                        MEM_AD_OE_O <= 1'b1;
                        MEM_ALE_O   <= 1'b1;
                        MEM_CS_N_O  <= 1'b0;
                        state_q     <= S_RALE;
                    end else if (CPU_REQ_I) begin
                        // Own bus drivers are already off in idle before buffers open
                        CPU_ADDR_BUF_EN_N_O      <= 1'b0;
                        CPU_DATA_BUF_EN_N_O      <= 1'b0;
                        PROCESSOR_WAIT_RELEASE_O <= 1'b1;
                        MEM_CS_N_O               <= 1'b0;
                        state_q                  <= S_GNT;
                    end
                end
                S_RALE: begin
                    MEM_ALE_O   <= 1'b0;
                    MEM_AD_OE_O <= 1'b0;
                    MEM_OE_N_O  <= 1'b0;
                    state_q     <= S_RD;
                end
                S_RD: begin
                    // One settling cycle for the memory output
                    state_q <= S_RCAP;
                end
                S_RCAP: begin
                    MEM_OE_N_O <= 1'b1;
                    if (!half_q) begin
                        cnt_q[15:0] <= MEM_AD_I;
                        half_q      <= 1'b1;
                        MEM_AD_O    <= {wadr_q, 1'b1};
                        MEM_AD_OE_O <= 1'b1;
                        MEM_ALE_O   <= 1'b1;
                        state_q     <= S_RALE;
                    end else begin
                        cnt_q[31:16] <= MEM_AD_I;
                        state_q      <= S_INC;
                    end
                end
                S_INC: begin
                    // Saturate so a full channel never wraps to zero
                    if (cnt_q != 32'hFFFF_FFFF) begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                    half_q      <= 1'b0;
                    MEM_AD_O    <= {wadr_q, 1'b0};
                    MEM_AD_OE_O <= 1'b1;
                    MEM_ALE_O   <= 1'b1;
                    state_q     <= S_WALE;
                end
                S_WALE: begin
                    MEM_ALE_O  <= 1'b0;
                    MEM_AD_O   <= {1'b0, (half_q ? cnt_q[31:16] : cnt_q[15:0])};
                    MEM_WE_N_O <= 1'b0;
                    state_q    <= S_WR;
                end
                S_WR: begin
                    MEM_WE_N_O <= 1'b1;
                    state_q    <= S_WEND;
                end
                S_WEND: begin
                    if (!half_q) begin
                        half_q    <= 1'b1;
                        MEM_AD_O  <= {wadr_q, 1'b1};
                        MEM_ALE_O <= 1'b1;
                        state_q   <= S_WALE;
                    end else begin
                        MEM_AD_OE_O <= 1'b0;
                        MEM_CS_N_O  <= 1'b1;
                        state_q     <= S_IDLE;
                    end
                end
                S_GNT: begin
                    // Processor strobes pass through only while granted
                    MEM_OE_N_O <= CPU_RD_N_I;
                    MEM_WE_N_O <= CPU_WR_N_I;
                    if (!CPU_REQ_I) begin
                        CPU_ADDR_BUF_EN_N_O      <= 1'b1;
                        CPU_DATA_BUF_EN_N_O      <= 1'b1;
                        PROCESSOR_WAIT_RELEASE_O <= 1'b0;
                        MEM_OE_N_O               <= 1'b1;
                        MEM_WE_N_O               <= 1'b1;
                        MEM_CS_N_O               <= 1'b1;
                        after_cpu_q              <= 1'b1;
                        state_q                  <= S_IDLE;
                    end
                end
                default: begin
                    MEM_AD_OE_O <= 1'b0;
                    MEM_CS_N_O  <= 1'b1;
                    state_q     <= S_IDLE;
                end
            endcase
        end
    end
endmodule // aqm_arbiter
`default_nettype wire

// *** aqm_defines.vh ***
// Purpose: Shared constants of the acquisition memory arbiter.
// Assumes: One 200 MHz clock, synchronous active-low reset.
// Notes:   Definitions only; included by its bare name.
`ifndef AQM_DEFINES_VH
`define AQM_DEFINES_VH

`define AQM_CLK_MHZ        200
`define AQM_ADDR_W         17
`define AQM_DATA_W         16
`define AQM_CHAN_W         15
`define AQM_CNT_W          32
`define AQM_FIFO_DEPTH     4
`define AQM_LT_W           32

// Live timer tick period and its cycle count
`define AQM_LT_TICK_US     10
`define AQM_LT_TICK_CYC    (`AQM_LT_TICK_US * `AQM_CLK_MHZ)

// Activity indicator stretch time and its cycle count
`define AQM_ACT_HOLD_MS    50
`define AQM_ACT_HOLD_CYC   (`AQM_ACT_HOLD_MS * 1000 * `AQM_CLK_MHZ)

`endif

// *** aqm_fifo.v ***
// Purpose: Small synchronous FIFO for queued conversions.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module aqm_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             push;
    wire             pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // aqm_fifo
`default_nettype wire

// *** aqm_live_timer.v ***
// Purpose: Externally gated live time counter for one ADC port.
// Assumes: Gate is synchronous to the clock.
// Notes:   Counts whole ticks only; a partial tick is held while the gate is low.
`timescale 1ns/1ps
`default_nettype none
module aqm_live_timer #(
    parameter        CW       = 32,
    parameter [15:0] TICK_CYC = 16'd2000
) (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          gate_i,
    input  wire          clear_i,
    output reg  [CW-1:0] count_o
);
    reg [15:0] pre_q;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_q   <= 16'h0000;
            count_o <= {CW{1'b0}};
        end else if (clear_i) begin
            pre_q   <= 16'h0000;
            count_o <= {CW{1'b0}};
        end else if (gate_i) begin
            if (pre_q == TICK_CYC - 16'h0001) begin
                pre_q   <= 16'h0000;
                count_o <= count_o + 1'b1;
            end else begin
                pre_q <= pre_q + 16'h0001;
            end
        end
    end
endmodule // aqm_live_timer
`default_nettype wire

// *** aqm_arbiter_checker.sv ***
// Purpose: Port-level protocol checks for the acquisition memory arbiter.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Attached by bind; watches top-level ports only.
`timescale 1ns/1ps
`default_nettype none
module aqm_arbiter_checker #(
    parameter [23:0] ACT_HOLD_CYC = 24'h00_0008
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic ADC1_READY_I,
    input wire logic ADC1_ACCEPT_O,
    input wire logic ADC2_ACCEPT_O,
    input wire logic PORT_ONE_ACTIVITY_LED_O,
    input wire logic PORT_TWO_ACTIVITY_LED_O,
    input wire logic CPU_REQ_I,
    input wire logic CPU_RD_N_I,
    input wire logic PROCESSOR_WAIT_RELEASE_O,
    input wire logic CPU_ADDR_BUF_EN_N_O,
    input wire logic CPU_DATA_BUF_EN_N_O,
    input wire logic MEM_AD_OE_O,
    input wire logic MEM_ALE_O,
    input wire logic MEM_CS_N_O,
    input wire logic MEM_OE_N_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Saturates so a long quiet spell cannot wrap back under the limit
    logic [7:0] since_acc_q;
    always @(posedge CLK_I) begin
        if (!RST_N_I || ADC1_ACCEPT_O)
            since_acc_q <= 8'h00;
        else if (since_acc_q != 8'hff)
            since_acc_q <= since_acc_q + 8'h01;
    end
    grant_excl_a: assert property (PROCESSOR_WAIT_RELEASE_O |-> !MEM_AD_OE_O && !MEM_ALE_O)
        else $error("block drives memory bus during grant");
    addr_iso_a: assert property (CPU_ADDR_BUF_EN_N_O == !PROCESSOR_WAIT_RELEASE_O)
        else $error("address buffer enable disagrees with grant");
    data_iso_a: assert property (CPU_DATA_BUF_EN_N_O == !PROCESSOR_WAIT_RELEASE_O)
        else $error("data buffer enable disagrees with grant");
    accept_cause_a: assert property (ADC1_ACCEPT_O |-> $past(ADC1_READY_I) ##1 !ADC1_ACCEPT_O)
        else $error("port one accept without ready or longer than one cycle");
    led_one_a: assert property (ADC1_ACCEPT_O |=> PORT_ONE_ACTIVITY_LED_O [*8])
        else $error("port one indicator not held after accept");
    led_two_a: assert property (ADC2_ACCEPT_O |=> PORT_TWO_ACTIVITY_LED_O [*8])
        else $error("port two indicator not held after accept");
    led_off_a: assert property (PORT_ONE_ACTIVITY_LED_O |-> since_acc_q <= ACT_HOLD_CYC + 2)
        else $error("port one indicator stays on too long");
    ale_frame_a: assert property (MEM_ALE_O |-> MEM_AD_OE_O && !MEM_CS_N_O ##1 !MEM_ALE_O)
        else $error("address strobe without driven bus");
    incr_seq_a: assert property ($fell(MEM_CS_N_O) && MEM_ALE_O
        |-> ##3 MEM_ALE_O ##4 MEM_ALE_O ##3 MEM_ALE_O ##3 MEM_CS_N_O)
        else $error("increment access sequence broken");
    stall_a: assert property ($rose(PROCESSOR_WAIT_RELEASE_O) |-> $past(MEM_CS_N_O))
        else $error("grant given in mid acquisition");
    grant_bound_a: assert property ($rose(CPU_REQ_I) |-> ##[1:20] PROCESSOR_WAIT_RELEASE_O)
        else $error("request not granted in time");
    strobe_fwd_a: assert property (PROCESSOR_WAIT_RELEASE_O && $past(PROCESSOR_WAIT_RELEASE_O)
        |-> MEM_OE_N_O == $past(CPU_RD_N_I))
        else $error("read strobe not forwarded during grant");
endmodule // aqm_arbiter_checker
bind aqm_arbiter aqm_arbiter_checker #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) i_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADC1_READY_I(ADC1_READY_I),
    .ADC1_ACCEPT_O(ADC1_ACCEPT_O), .ADC2_ACCEPT_O(ADC2_ACCEPT_O),
    .PORT_ONE_ACTIVITY_LED_O(PORT_ONE_ACTIVITY_LED_O),
    .PORT_TWO_ACTIVITY_LED_O(PORT_TWO_ACTIVITY_LED_O), .CPU_REQ_I(CPU_REQ_I),
    .CPU_RD_N_I(CPU_RD_N_I), .PROCESSOR_WAIT_RELEASE_O(PROCESSOR_WAIT_RELEASE_O),
    .CPU_ADDR_BUF_EN_N_O(CPU_ADDR_BUF_EN_N_O), .CPU_DATA_BUF_EN_N_O(CPU_DATA_BUF_EN_N_O),
    .MEM_AD_OE_O(MEM_AD_OE_O), .MEM_ALE_O(MEM_ALE_O), .MEM_CS_N_O(MEM_CS_N_O),
    .MEM_OE_N_O(MEM_OE_N_O));
`default_nettype wire

// *** aqm_sram_model.sv ***
// Purpose: Acquisition static RAM with address latch on the multiplexed bus.
// Assumes: Strobes sampled on the rising clock edge.
// Notes:   Read data holds one cycle after output enable rises, then goes stale-inverted.
`timescale 1ns/1ps
`default_nettype none
module aqm_sram_model (
    input  wire logic        clk_i,
    input  wire logic [16:0] ad_i,
    input  wire logic        ale_i,
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    output wire logic [15:0] rd_o
);
    logic [15:0] mem [0:131071];
    logic [16:0] lat_q = 17'h0_0000;
    logic        hold_q = 1'b0;
    logic [15:0] last_q = 16'h0000;
    initial begin
        for (int i = 0; i < 131072; i++)
            mem[i] = 16'h0000;
    end
    always @(posedge clk_i) begin
        if (ale_i)
            lat_q <= ad_i;
        if (!cs_n_i && !we_n_i)
            mem[lat_q] <= ad_i[15:0];
        hold_q <= !cs_n_i && !oe_n_i;
        last_q <= rd_o;
    end
    // A released bus must not look like the last word, so it shows its inverse
    assign rd_o = (!cs_n_i && (!oe_n_i || hold_q)) ? mem[lat_q] : ~last_q;
endmodule // aqm_sram_model
`default_nettype wire

// *** aqm_arbiter_tb_top.sv ***
// Purpose: Self-checking bench for the acquisition memory arbiter.
// Assumes: 200 MHz clock; short indicator and tick counts for speed.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "aqm_defines.vh"
module aqm_arbiter_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, rd_n = 1'b1, clr = 1'b0;
    logic [1:0] rdy = 2'b00, gate = 2'b00, acc, led;
    logic [14:0] ch [2] = '{15'h0000, 15'h0000};
    logic [31:0] lt1, lt2, seed = 32'h0000_a934;
    logic rel, aen_n, den_n, adoe, ale, cs_n, oe_n, we_n;
    logic [16:0] ad;
    logic [15:0] adi;
    logic [31:0] expc [int];
    int err_count = 0, n_tests = 0;

    aqm_arbiter #(.ACT_HOLD_CYC(24'h00_0008), .LT_TICK_CYC(16'h0004)) i_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .ADC1_CHAN_I(ch[0]), .ADC1_READY_I(rdy[0]),
        .ADC1_ACCEPT_O(acc[0]), .ADC2_CHAN_I(ch[1]), .ADC2_READY_I(rdy[1]),
        .ADC2_ACCEPT_O(acc[1]), .LT1_GATE_I(gate[0]), .LT2_GATE_I(gate[1]),
        .LT_CLEAR_I(clr), .LT1_COUNT_O(lt1), .LT2_COUNT_O(lt2),
        .PORT_ONE_ACTIVITY_LED_O(led[0]), .PORT_TWO_ACTIVITY_LED_O(led[1]),
        .CPU_REQ_I(req), .CPU_RD_N_I(rd_n), .CPU_WR_N_I(1'b1),
        .PROCESSOR_WAIT_RELEASE_O(rel), .CPU_ADDR_BUF_EN_N_O(aen_n),
        .CPU_DATA_BUF_EN_N_O(den_n), .MEM_AD_O(ad), .MEM_AD_OE_O(adoe), .MEM_AD_I(adi),
        .MEM_ALE_O(ale), .MEM_CS_N_O(cs_n), .MEM_OE_N_O(oe_n), .MEM_WE_N_O(we_n));
    aqm_sram_model i_mem (.clk_i(clk), .ad_i(ad), .ale_i(ale), .cs_n_i(cs_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .rd_o(adi));

    initial forever #2.5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Counts stick at full scale rather than wrapping to zero
    function automatic logic [31:0] inc_sat(input logic [31:0] v);
        return (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic convert(input int p, input logic [14:0] c);
        int k;
        k = p * 32768 + c;
        if (!expc.exists(k))
            expc[k] = {i_mem.mem[2 * k + 1], i_mem.mem[2 * k]};
        expc[k] = inc_sat(expc[k]);
        ch[p] = c;
        rdy[p] = 1'b1;
        for (k = 0; k < 100 && acc[p] !== 1'b1; k++)
            tick(1);
        check("accept", 32'(acc[p]), 32'h0000_0001);
        tick(1);
        check("indicator on", 32'(led[p]), 32'h0000_0001);
        rdy[p] = 1'b0;
        tick(1);
    endtask
    task automatic burst(input int p, input int n);
        repeat (n) begin
            seed = lfsr(seed);
            convert(p, seed[14:0] & 15'h4007);
        end
    endtask
    task automatic drain_and_compare(input string name);
        int idle;
        idle = 0;
        for (int i = 0; i < 2000 && idle < 20; i++) begin
            tick(1);
            idle = (cs_n === 1'b1 && rdy === 2'b00) ? idle + 1 : 0;
        end
        foreach (expc[k])
            check("channel count", {i_mem.mem[2 * k + 1], i_mem.mem[2 * k]}, expc[k]);
        $display("test %s done", name);
    endtask
    task automatic cpu_access;
        int k;
        req = 1'b1;
        for (k = 0; k < 40 && rel !== 1'b1; k++)
            tick(1);
        check("grant", {29'h0000_0000, rel, aen_n, den_n}, 32'h0000_0004);
        check("bus drive in grant", 32'(adoe), 32'h0000_0000);
        rd_n = 1'b0;
        tick(2);
        check("forwarded read", 32'(oe_n), 32'h0000_0000);
        rd_n = 1'b1;
        req = 1'b0;
        tick(2);
        check("release", {29'h0000_0000, rel, aen_n, den_n}, 32'h0000_0003);
    endtask

    initial begin
        tick(10);
        rst_n = 1'b1;
        check("idle outputs", {26'h000_0000, rel, aen_n, den_n, cs_n, led}, 32'h0000_001c);
        i_mem.mem[0] = 16'hffff;
        i_mem.mem[131070] = 16'hfffe;
        i_mem.mem[131071] = 16'hffff;
        convert(0, 15'h0000);
        convert(1, 15'h7fff);
        convert(1, 15'h7fff);
        drain_and_compare("carry and saturation");
        fork
            burst(0, 12);
            burst(1, 12);
        join
        drain_and_compare("both ports full queue");
        tick(12);
        check("indicators off", 32'(led), 32'h0000_0000);
        fork
            burst(0, 10);
            burst(1, 10);
            repeat (3) cpu_access();
        join
        drain_and_compare("processor during acquisition");
        seed = lfsr(seed);
        for (int i = 0; i < 32; i++) begin
            gate[0] = (i < 4 * seed[2:0]);
            gate[1] = (i < 4 * seed[5:3]);
            tick(1);
        end
        tick(3);
        check("live time one", lt1, 32'(seed[2:0]));
        check("live time two", lt2, 32'(seed[5:3]));
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(2);
        check("live time clear", lt1 | lt2, 32'h0000_0000);
        $display("test live timers done");
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule // aqm_arbiter_tb_top
`default_nettype wire
